// ==== rtl/adc_gain_pkg.sv ====
`default_nettype none
package adc_gain_pkg;
  localparam int          ADDR_W        = 7;
  localparam int          DATA_W        = 8;
  localparam logic [6:0]  OFS_RSVD      = 7'h0D;
  localparam logic [6:0]  OFS_HEADSET   = 7'h0E;
  localparam logic [6:0]  OFS_LEFT_PGA  = 7'h0F;
  localparam logic [6:0]  OFS_RIGHT_PGA = 7'h10;
  localparam logic [6:0]  OFS_AUX_LEFT  = 7'h11;
  // headset field positions
  localparam int          HS_ACCPL_BIT  = 7;
  localparam int          HS_FDIFF_BIT  = 6;
  localparam int          HS_PDIFF_BIT  = 3;
  localparam logic [7:0]  HS_WR_MASK    = 8'hC8;
  // pga fields
  localparam int          PGA_MUTE_BIT  = 7;
  localparam logic [6:0]  PGA_GAIN_MAX  = 7'h77;
  // aux level fields
  localparam logic [3:0]  AUX_LVL_MAX   = 4'h8;
  localparam logic [3:0]  AUX_LVL_OFF   = 4'hF;
  // reset values
  localparam logic [7:0]  RST_RSVD      = 8'h00;
  localparam logic [7:0]  RST_HEADSET   = 8'h00;
  localparam logic [7:0]  RST_PGA       = 8'h80;
  localparam logic [7:0]  RST_AUX_LEFT  = 8'hFF;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       mute;
    logic [6:0] gain;
  } pga_ctl_t;

  typedef struct packed {
    logic       connect;
    logic [3:0] atten;
  } aux_route_t;

  typedef struct packed {
    logic ac_coupled;
    logic fully_diff;
    logic pseudo_diff;
  } headset_ctl_t;
endpackage : adc_gain_pkg
`default_nettype wire

// ==== rtl/adc_gain_and_headset_config_regs.sv ====
// Contract
// - Headset bit 7 picks capless (0) or ac-coupled (1) drivers, reset 0.
// - Headset bit 6 flags a fully-differential stereo output in use, reset 0.
// - Headset bit 3 flags a pseudo-differential stereo output in use, reset 0.
// - Left record amp register bit 7 mutes the left amp, reset 1.
// - Left gain is 0.5 dB per code from 0 dB, saturating from code 0x77.
// - Right record amp register bit 7 mutes the right amp, reset 1.
// - Right gain uses the left encoding, saturating at 59.5 dB from 0x77.
// - Aux left level codes 0..8 connect it to the left mixer, 1.5 dB/step.
// - Aux left level code 0xF, the reset value, disconnects it.
// - Aux right level field uses the same encoding, reset 0xF disconnected.
`default_nettype none
module adc_gain_and_headset_config_regs
  import adc_gain_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // register port
  input  wire reg_req_t      req,
  output var  logic [7:0]    rdata,
  output var  logic          rvalid,
  // controls to analog
  output var  headset_ctl_t  headset,
  output var  pga_ctl_t      left_pga,
  output var  pga_ctl_t      right_pga,
  output var  aux_route_t    aux_mic_left_input,
  output var  aux_route_t    aux_mic_right_input
);

  logic [7:0]   rsvd_ff,   nxt_rsvd;
  logic [7:0]   hs_ff,     nxt_hs;
  logic [7:0]   lpga_ff,   nxt_lpga;
  logic [7:0]   rpga_ff,   nxt_rpga;
  logic [7:0]   aux_ff,    nxt_aux;
  logic [7:0]   rdata_ff,  nxt_rdata;
  logic         rvalid_ff, nxt_rvalid;
  headset_ctl_t hsctl_ff,  nxt_hsctl;
  pga_ctl_t     lctl_ff,   nxt_lctl;
  pga_ctl_t     rctl_ff,   nxt_rctl;
  aux_route_t   alctl_ff,  nxt_alctl;
  aux_route_t   arctl_ff,  nxt_arctl;

  // reserved codes map to disconnect so the mixer never sees an undefined level
  function automatic aux_route_t aux_decode(input logic [3:0] code);
    aux_route_t r;
    r.connect = (code <= AUX_LVL_MAX);
    r.atten   = r.connect ? code : AUX_LVL_OFF;
    return r;
  endfunction : aux_decode

  function automatic pga_ctl_t pga_decode(input logic [7:0] v);
    pga_ctl_t p;
    p.mute = v[PGA_MUTE_BIT];
    // clamp so the analog stage sees one code for the saturated range
    p.gain = (v[6:0] > PGA_GAIN_MAX) ? PGA_GAIN_MAX : v[6:0];
    return p;
  endfunction : pga_decode

  always_comb begin
    nxt_rsvd = rsvd_ff;
    nxt_hs   = hs_ff;
    nxt_lpga = lpga_ff;
    nxt_rpga = rpga_ff;
    nxt_aux  = aux_ff;
    if (req.wr) begin
      if (req.addr == OFS_RSVD) begin
        nxt_rsvd = req.wdata;
      end else if (req.addr == OFS_HEADSET) begin
        // read-only reserved bits never take a write
        nxt_hs = req.wdata & HS_WR_MASK;
      end else if (req.addr == OFS_LEFT_PGA) begin
        nxt_lpga = req.wdata;
      end else if (req.addr == OFS_RIGHT_PGA) begin
        nxt_rpga = req.wdata;
      end else if (req.addr == OFS_AUX_LEFT) begin
        nxt_aux = req.wdata;
      end
    end
  end

  always_comb begin
    nxt_rvalid = req.rd;
    nxt_rdata  = 8'h00;
    if (req.rd) begin
      if (req.addr == OFS_RSVD) begin
        nxt_rdata = rsvd_ff;
      end else if (req.addr == OFS_HEADSET) begin
        nxt_rdata = hs_ff;
      end else if (req.addr == OFS_LEFT_PGA) begin
        nxt_rdata = lpga_ff;
      end else if (req.addr == OFS_RIGHT_PGA) begin
        nxt_rdata = rpga_ff;
      end else if (req.addr == OFS_AUX_LEFT) begin
        nxt_rdata = aux_ff;
      end
    end
  end

  always_comb begin
    nxt_hsctl.ac_coupled  = nxt_hs[HS_ACCPL_BIT];
    nxt_hsctl.fully_diff  = nxt_hs[HS_FDIFF_BIT];
    // no arbitration when both set; software keeps them exclusive
    nxt_hsctl.pseudo_diff = nxt_hs[HS_PDIFF_BIT];
    nxt_lctl  = pga_decode(nxt_lpga);
    nxt_rctl  = pga_decode(nxt_rpga);
    nxt_alctl = aux_decode(nxt_aux[7:4]);
    nxt_arctl = aux_decode(nxt_aux[3:0]);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rsvd_ff   <= RST_RSVD;
      hs_ff     <= RST_HEADSET;
      lpga_ff   <= RST_PGA;
      rpga_ff   <= RST_PGA;
      aux_ff    <= RST_AUX_LEFT;
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
      hsctl_ff  <= '0;
      lctl_ff   <= '{mute: 1'b1, gain: 7'h00};
      rctl_ff   <= '{mute: 1'b1, gain: 7'h00};
      alctl_ff  <= '{connect: 1'b0, atten: AUX_LVL_OFF};
      arctl_ff  <= '{connect: 1'b0, atten: AUX_LVL_OFF};
    end else begin
      rsvd_ff   <= nxt_rsvd;
      hs_ff     <= nxt_hs;
      lpga_ff   <= nxt_lpga;
      rpga_ff   <= nxt_rpga;
      aux_ff    <= nxt_aux;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      hsctl_ff  <= nxt_hsctl;
      lctl_ff   <= nxt_lctl;
      rctl_ff   <= nxt_rctl;
      alctl_ff  <= nxt_alctl;
      arctl_ff  <= nxt_arctl;
    end
  end

  assign rdata               = rdata_ff;
  assign rvalid              = rvalid_ff;
  assign headset             = hsctl_ff;
  assign left_pga            = lctl_ff;
  assign right_pga           = rctl_ff;
  assign aux_mic_left_input  = alctl_ff;
  assign aux_mic_right_input = arctl_ff;

endmodule : adc_gain_and_headset_config_regs
`default_nettype wire

// ==== test/adc_regs_asserts.sv ====
`default_nettype none
module adc_regs_asserts
  import adc_gain_pkg::*;
(
  // watched ports
  input wire logic         clk,
  input wire logic         resetn,
  input wire reg_req_t     req,
  input wire logic [7:0]   rdata,
  input wire logic         rvalid,
  input wire headset_ctl_t headset,
  input wire pga_ctl_t     left_pga,
  input wire pga_ctl_t     right_pga,
  input wire aux_route_t   aux_mic_left_input,
  input wire aux_route_t   aux_mic_right_input
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic       hw = req.wr && req.addr == OFS_HEADSET;
  wire logic       lw = req.wr && req.addr == OFS_LEFT_PGA;
  wire logic       rw = req.wr && req.addr == OFS_RIGHT_PGA;
  wire logic       aw = req.wr && req.addr == OFS_AUX_LEFT;
  wire logic [3:0] lc = req.wdata[7:4];
  wire logic [6:0] g  = req.wdata[6:0];
  // gain saturates at the output only, the register keeps the raw code
  wire logic [7:0] pg = {req.wdata[7], g > PGA_GAIN_MAX ? PGA_GAIN_MAX : g};
  chk_ac_mode:
    assert property (hw |=> headset.ac_coupled == $past(req.wdata[7]))
    else $error("ac coupling mode wrong");
  chk_full_diff:
    assert property (hw |=> headset.fully_diff == $past(req.wdata[6]))
    else $error("fully differential flag wrong");
  chk_pseudo_diff:
    assert property (hw |=> headset.pseudo_diff == $past(req.wdata[3]))
    else $error("pseudo differential flag wrong");
  chk_left_pga:
    assert property (lw |=> left_pga == $past(pg))
    else $error("left amplifier control wrong");
  chk_right_pga:
    assert property (rw |=> right_pga == $past(pg))
    else $error("right amplifier control wrong");
  chk_aux_connect:
    assert property (aw && lc <= AUX_LVL_MAX
      |=> aux_mic_left_input == {1'b1, $past(lc)})
    else $error("left aux connect wrong");
  chk_aux_off:
    assert property (aw && lc == AUX_LVL_OFF
      |=> !aux_mic_left_input.connect)
    else $error("left aux not disconnected");
  chk_aux_right:
    assert property (aw |=> aux_mic_right_input.connect
      == ($past(req.wdata[3:0]) <= AUX_LVL_MAX))
    else $error("right aux connect wrong");
  cover property (hw && req.wdata[7]);
  cover property (lw && g > PGA_GAIN_MAX);
  cover property (aw && lc == AUX_LVL_OFF);
endmodule : adc_regs_asserts
bind adc_gain_and_headset_config_regs adc_regs_asserts u_chk (.clk,
  .resetn, .req, .rdata, .rvalid, .headset, .left_pga, .right_pga,
  .aux_mic_left_input, .aux_mic_right_input);
`default_nettype wire

// ==== test/adc_gain_and_headset_config_regs_tb.sv ====
`default_nettype none
module adc_gain_and_headset_config_regs_tb
  import adc_gain_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0;
  logic         resetn = 1'b0;
  reg_req_t     req = '0;
  logic [7:0]   rdata;
  logic         rvalid;
  headset_ctl_t headset;
  pga_ctl_t     lp, rp;
  aux_route_t   al, ar;
  int           failures, total_checks, cycles;
  always #4 clk = ~clk;
  adc_gain_and_headset_config_regs uut (.clk, .resetn, .req, .rdata,
    .rvalid, .headset, .left_pga(lp), .right_pga(rp),
    .aux_mic_left_input(al), .aux_mic_right_input(ar));
  task automatic give_verdict;
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [6:0] sat(input logic [6:0] v);
    return v > PGA_GAIN_MAX ? PGA_GAIN_MAX : v;
  endfunction : sat
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) req <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) req <= '0;
    #1 chk({7'h00, rvalid}, 8'h01);
    chk(rdata, e);
  endtask : rd
  task automatic reset_values;
    chk({5'h00, headset}, 8'h00);
    chk(lp, RST_PGA);
    chk({3'h0, ar}, 8'h0F);
    wr(OFS_RSVD, 8'h00);
    rd(OFS_RSVD, RST_RSVD);
    rd(OFS_AUX_LEFT, RST_AUX_LEFT);
    rd(OFS_RIGHT_PGA, RST_PGA);
    rd(7'h12, 8'h00);
  endtask : reset_values
  task automatic headset_modes;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = i == 0 ? 8'h80 : i == 1 ? 8'h40 : i == 2 ? 8'h08 : 8'h00;
      wr(OFS_HEADSET, d);
      chk({5'h00, headset}, {5'h00, d[7], d[6], d[3]});
      rd(OFS_HEADSET, d);
    end
  endtask : headset_modes
  task automatic pga_gain;
    logic [6:0] g;
    for (int i = 0; i < 6; i++) begin
      // codes straddle the point where the gain saturates
      g = i == 5 ? 7'h7F : 7'h74 + 7'(i);
      wr(OFS_LEFT_PGA, {i[0], g});
      wr(OFS_RIGHT_PGA, {~i[0], g ^ 7'h01});
      chk(lp, {i[0], sat(g)});
      chk(rp, {~i[0], sat(g ^ 7'h01)});
      rd(OFS_LEFT_PGA, {i[0], g});
    end
  endtask : pga_gain
  task automatic aux_levels;
    logic [3:0] c, r;
    for (int i = 0; i < 10; i++) begin
      c = i == 9 ? 4'hF : 4'(i);
      r = i == 0 ? 4'hF : 4'(i - 1);
      wr(OFS_AUX_LEFT, {c, r});
      chk({3'h0, al}, c == 4'hF ? 8'h0F : {4'h1, c});
      chk({3'h0, ar}, r == 4'hF ? 8'h0F : {4'h1, r});
      rd(OFS_AUX_LEFT, {c, r});
    end
  endtask : aux_levels
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      give_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    #1 reset_values;
    headset_modes;
    pga_gain;
    aux_levels;
    give_verdict;
  end
endmodule : adc_gain_and_headset_config_regs_tb
`default_nettype wire
